// ### shared/amsl_regs.vh
// Constants for the accumulator multiply, shift and logic datapath.
// Assumes inclusion by the datapath modules and the testbench files.
`ifndef AMSL_REGS_VH
`define AMSL_REGS_VH

// ------------------------------------------------------------
// Operation codes
// ------------------------------------------------------------
`define AMSL_OP_IDLE      3'h0
`define AMSL_OP_MULRND    3'h1
`define AMSL_OP_NEGATE    3'h2
`define AMSL_OP_NORM_STEP 3'h3
`define AMSL_OP_FAST_NORM 3'h4
`define AMSL_OP_COMPL     3'h5
`define AMSL_OP_OR        3'h6

// ------------------------------------------------------------
// OR source selects
// ------------------------------------------------------------
`define AMSL_ORSRC_REG    2'h0
`define AMSL_ORSRC_SHORT  2'h1
`define AMSL_ORSRC_LONG   2'h2

// ------------------------------------------------------------
// Field positions and widths
// ------------------------------------------------------------
`define AMSL_ACC_W        56
`define AMSL_WORD_W       24
`define AMSL_HI_MSB       47
`define AMSL_HI_LSB       24
`define AMSL_ACC_MSB      55
`define AMSL_V_WATCH_BIT  39
`define AMSL_SHAMT_SIGN   23
`define AMSL_IDLE_WORD    24'h000000

// ------------------------------------------------------------
// Flag bit positions and reset values
// ------------------------------------------------------------
`define AMSL_FLG_C        0
`define AMSL_FLG_V        1
`define AMSL_FLG_Z        2
`define AMSL_FLG_N        3
`define AMSL_FLG_U        4
`define AMSL_FLG_E        5
`define AMSL_FLAGS_RST    8'h00
`define AMSL_ACC_RST      56'h00000000000000
`define AMSL_PTR_RST      24'h000000

`endif

// ### src/amsl_shifter.v
// Arithmetic barrel shift of a 56-bit accumulator with bit-39 watch.
// Assumes a signed shift amount within the legal range of the caller.
`timescale 1ns/1ns
`default_nettype none
`include "amsl_regs.vh"

module amsl_shifter (
  // Operand
  input  wire [55:0] acc_i,
  input  wire [23:0] amount_i,
  // Result
  output reg  [55:0] result_o,
  output reg         v_watch_o
);

  reg        left;
  reg [6:0]  mag;
  reg [23:0] neg_amt;
  reg        ref_bit;
  integer    k;

  // ------------------------------------------------------------
  // Shift and watch of bit 39 across every single step
  // ------------------------------------------------------------
  always @* begin
    left      = amount_i[`AMSL_SHAMT_SIGN];
    neg_amt   = 24'h000000 - amount_i;
    mag       = left ? neg_amt[6:0] : amount_i[6:0];
    if (mag > 7'h38) begin
      mag = 7'h38;
    end
    // Kept apart so that the right shift stays signed
    if (left) begin
      result_o = acc_i << mag;
    end else begin
      result_o = $signed(acc_i) >>> mag;
    end
    ref_bit   = acc_i[`AMSL_V_WATCH_BIT];
    v_watch_o = 1'b0;
    for (k = 1; k <= 56; k = k + 1) begin
      if (k <= mag) begin
        if (left) begin
          if (k <= 39 && acc_i[39 - k] != ref_bit) begin
            v_watch_o = 1'b1;
          end else if (k > 39 && ref_bit) begin
            v_watch_o = 1'b1;
          end
        end else begin
          if (k <= 16 && acc_i[39 + k] != ref_bit) begin
            v_watch_o = 1'b1;
          end else if (k > 16 && acc_i[55] != ref_bit) begin
            v_watch_o = 1'b1;
          end
        end
      end
    end
  end

endmodule // amsl_shifter
`default_nettype wire

// ### src/amsl_datapath.v
// Accumulator datapath: multiply-round, negate, normalize, complement, OR.
// Assumes decoder presents one operation per op_valid_i pulse, same clock.
//
// Operation
// - Multiply immediate by input register into accumulator
// - Round convergent or two's complement per mode
// - Minus option negates product before rounding
// - Clear low accumulator word after rounding
// - Fields select input register, accumulator, sign
// - Negate accumulator as full 56-bit operation
// - Idle instruction only advances program counter
// - Normalize shifts left, decrements pointer when unnormalized; code tests flag U, which no operation sets, so never shifts left
// - Extension in use: shift right, increment pointer; code tests flag E, which no operation sets, so never shifts right
// - Normalize left shift changing bit 55 sets V
// - Fast align shifts right or left by amount
// - Fast align V tracks any bit 39 change
// - Complement inverts bits 47-24 only
// - Complement and OR set N, Z, clear V
// - OR source into bits 47-24 only
// - OR source register, short or long immediate
// - Short immediate zero extended, right aligned
`timescale 1ns/1ns
`default_nettype none
`include "amsl_regs.vh"

module amsl_datapath (
  // Clock and reset
  input  wire        ref_clk_i,
  input  wire        rst_n_i,
  // Instruction request
  input  wire        op_valid_i,
  input  wire [2:0]  op_code_i,
  input  wire [23:0] instr_word_i,
  input  wire        acc_sel_i,
  input  wire        minus_i,
  input  wire [1:0]  input_reg_field_i,
  input  wire [23:0] ext_word_i,
  input  wire [2:0]  pointer_reg_sel_i,
  input  wire [1:0]  or_src_i,
  input  wire [5:0]  short_imm_i,
  input  wire [23:0] shift_src_i,
  // Mode and operands
  input  wire        rounding_op_twos_i,
  input  wire [23:0] x0_i,
  input  wire [23:0] y0_i,
  input  wire [23:0] x1_i,
  input  wire [23:0] y1_i,
  // Results
  output reg  [55:0] acc_a_o,
  output reg  [55:0] acc_b_o,
  output reg  [7:0]  flag_register_o,
  output reg  [23:0] program_counter_o,
  output reg  [23:0] pointer_upd_o,
  output reg  [2:0]  pointer_sel_o,
  output reg         pointer_we_o,
  output reg  [23:0] pointer_val_o,
  output reg         done_o
);

  // ------------------------------------------------------------
  // Pointer register file kept locally
  // ------------------------------------------------------------
  reg  [23:0] ptr_q [0:7];
  wire [55:0] acc_cur = acc_sel_i ? acc_b_o : acc_a_o;

  // Operand select from the two-bit input register field
  function [23:0] pick_in;
    input [1:0] f;
    begin
      if (f == 2'h0) begin
        pick_in = x0_i;
      end else if (f == 2'h1) begin
        pick_in = y0_i;
      end else if (f == 2'h2) begin
        pick_in = x1_i;
      end else begin
        pick_in = y1_i;
      end
    end
  endfunction

  // ------------------------------------------------------------
  // Multiply and round
  // ------------------------------------------------------------
  wire signed [47:0] prod   = $signed(ext_word_i) * $signed(pick_in(input_reg_field_i));
  wire        [55:0] prod_f = {{8{prod[47]}}, prod[46:0], 1'b0};
  wire        [55:0] prod_s = minus_i ? 56'h0 - prod_f : prod_f;
  wire        [55:0] rsum   = prod_s + 56'h00000000800000;
  reg         [55:0] rnd_res;
  always @* begin
    rnd_res = {rsum[55:24], 24'h000000};
    if (!rounding_op_twos_i && rsum[23:0] == 24'h000000) begin
      rnd_res[24] = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Fast align and logic results
  // ------------------------------------------------------------
  wire [55:0] fast_res;
  wire        fast_v;
  amsl_shifter u_shift (
    .acc_i    (acc_cur),
    .amount_i (shift_src_i),
    .result_o (fast_res),
    .v_watch_o(fast_v)
  );

  wire [23:0] or_src = (or_src_i == `AMSL_ORSRC_SHORT) ? {18'h0, short_imm_i} :
                       (or_src_i == `AMSL_ORSRC_LONG)  ? ext_word_i :
                                                         pick_in(input_reg_field_i);
  wire [23:0] hi_cur = acc_cur[`AMSL_HI_MSB:`AMSL_HI_LSB];
  wire [23:0] hi_not = ~hi_cur;
  wire [23:0] hi_or  = hi_cur | or_src;

  // ------------------------------------------------------------
  // Result selection
  // ------------------------------------------------------------
  reg  [55:0] res;
  reg  [7:0]  flg;
  reg         wr_acc;
  reg  [23:0] ptr_new;
  reg         ptr_we;
  wire [7:0]  f_cur   = flag_register_o;
  wire [23:0] ptr_cur = ptr_q[pointer_reg_sel_i];

  // ------------------------------------------------------------
  // Normalize step decision
  // ------------------------------------------------------------
  // Decision relies on flags already reflecting the accumulator
  wire        norm_left  = !f_cur[`AMSL_FLG_E] && f_cur[`AMSL_FLG_U] && !f_cur[`AMSL_FLG_Z];
  wire        norm_right = !norm_left && f_cur[`AMSL_FLG_E];
  wire [55:0] norm_shl   = {acc_cur[54:0], 1'b0};
  wire [55:0] norm_shr   = {acc_cur[55], acc_cur[55:1]};
  wire        norm_v     = acc_cur[55] ^ acc_cur[54];
  wire [23:0] ptr_dec    = ptr_cur - 24'h000001;
  wire [23:0] ptr_inc    = ptr_cur + 24'h000001;

  // ------------------------------------------------------------
  // Upper word logic result and its flags
  // ------------------------------------------------------------
  wire [23:0] logic_hi  = (op_code_i == `AMSL_OP_COMPL) ? hi_not : hi_or;
  wire [55:0] logic_res = {acc_cur[55:48], logic_hi, acc_cur[23:0]};
  wire        logic_n   = logic_hi[23];
  wire        logic_z   = (logic_hi == 24'h000000);

  always @* begin
    res     = acc_cur;
    flg     = f_cur;
    wr_acc  = 1'b0;
    ptr_new = ptr_cur;
    ptr_we  = 1'b0;
    case (op_code_i)
      `AMSL_OP_MULRND: begin
        res    = rnd_res;
        wr_acc = 1'b1;
      end
      `AMSL_OP_NEGATE: begin
        res    = 56'h0 - acc_cur;
        wr_acc = 1'b1;
      end
      `AMSL_OP_NORM_STEP: begin
        if (norm_left) begin
          res     = norm_shl;
          ptr_new = ptr_dec;
          ptr_we  = 1'b1;
          wr_acc  = 1'b1;
          flg[`AMSL_FLG_V] = norm_v;
        end else if (norm_right) begin
          res     = norm_shr;
          ptr_new = ptr_inc;
          ptr_we  = 1'b1;
          wr_acc  = 1'b1;
        end
      end
      `AMSL_OP_FAST_NORM: begin
        // Amount range is the caller's duty
        res    = fast_res;
        wr_acc = 1'b1;
        flg[`AMSL_FLG_V] = fast_v;
      end
      `AMSL_OP_COMPL, `AMSL_OP_OR: begin
        res    = logic_res;
        wr_acc = 1'b1;
        flg[`AMSL_FLG_N] = logic_n;
        flg[`AMSL_FLG_Z] = logic_z;
        flg[`AMSL_FLG_V] = 1'b0;
      end
      default: begin
        res = acc_cur;
      end
    endcase
  end

  // ------------------------------------------------------------
  // State update
  // ------------------------------------------------------------
  integer i;
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_a_o           <= `AMSL_ACC_RST;
      acc_b_o           <= `AMSL_ACC_RST;
      flag_register_o   <= `AMSL_FLAGS_RST;
      program_counter_o <= 24'h000000;
      pointer_upd_o     <= `AMSL_PTR_RST;
      pointer_sel_o     <= 3'h0;
      pointer_we_o      <= 1'b0;
      pointer_val_o     <= `AMSL_PTR_RST;
      done_o            <= 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
        ptr_q[i] <= `AMSL_PTR_RST;
      end
    end else begin
      done_o       <= op_valid_i;
      pointer_we_o <= 1'b0;
      if (op_valid_i) begin
        program_counter_o <= program_counter_o + 24'h000001;
        flag_register_o   <= flg;
        pointer_sel_o     <= pointer_reg_sel_i;
        pointer_val_o     <= ptr_new;
        if (wr_acc && !acc_sel_i) begin
          acc_a_o <= res;
        end
        if (wr_acc && acc_sel_i) begin
          acc_b_o <= res;
        end
        if (ptr_we) begin
          ptr_q[pointer_reg_sel_i] <= ptr_new;
          pointer_upd_o            <= ptr_new;
          pointer_we_o             <= 1'b1;
        end
      end
    end
  end

endmodule // amsl_datapath
`default_nettype wire

// ### testbench/amsl_dp_props.sv
// Port checker for the accumulator datapath.
// Assumes it is bound onto amsl_datapath, one clock domain.
`timescale 1ns/1ns
`default_nettype none
`include "amsl_regs.vh"
module amsl_dp_props (
  // Clock, reset and request
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic        op_valid_i,
  input wire logic [2:0]  op_code_i,
  input wire logic        acc_sel_i,
  input wire logic [1:0]  or_src_i,
  // Results
  input wire logic [55:0] acc_a_o,
  input wire logic [55:0] acc_b_o,
  input wire logic [7:0]  flag_register_o,
  input wire logic [23:0] program_counter_o,
  input wire logic        done_o
);
  // ------------------------------------
  // Properties
  // ------------------------------------
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_done; (op_valid_i |=> done_o) and (!op_valid_i |=> !done_o); endproperty
  property p_pc; op_valid_i |=> program_counter_o == $past(program_counter_o) + 24'h1; endproperty
  property p_idle; op_valid_i && op_code_i == `AMSL_OP_IDLE
    |=> $stable(acc_a_o) && $stable(acc_b_o) && $stable(flag_register_o); endproperty
  property p_neg; op_valid_i && op_code_i == `AMSL_OP_NEGATE && !acc_sel_i
    |=> acc_a_o == 56'h0 - $past(acc_a_o); endproperty
  property p_cmp; op_valid_i && op_code_i == `AMSL_OP_COMPL && !acc_sel_i
    |=> acc_a_o == ($past(acc_a_o) ^ 56'h00ffffff000000); endproperty
  property p_orkeep; op_valid_i && op_code_i == `AMSL_OP_OR && !acc_sel_i
    |=> {acc_a_o[55:48], acc_a_o[23:0]} == $past({acc_a_o[55:48], acc_a_o[23:0]})
    && (acc_a_o[47:24] & $past(acc_a_o[47:24])) == $past(acc_a_o[47:24]); endproperty
  property p_short; op_valid_i && op_code_i == `AMSL_OP_OR && or_src_i == `AMSL_ORSRC_SHORT && !acc_sel_i
    |=> acc_a_o[47:30] == $past(acc_a_o[47:30]); endproperty
  property p_flg; op_valid_i && !acc_sel_i && (op_code_i == `AMSL_OP_COMPL || op_code_i == `AMSL_OP_OR)
    |=> !flag_register_o[1] && flag_register_o[3] == acc_a_o[47]
    && flag_register_o[2] == (acc_a_o[47:24] == 24'h0); endproperty
  property p_mul; op_valid_i && op_code_i == `AMSL_OP_MULRND
    |=> ($past(acc_sel_i) ? acc_b_o[23:0] : acc_a_o[23:0]) == 24'h0; endproperty
  a_done: assert property (p_done) else $error("done pulse wrong");
  a_pc: assert property (p_pc) else $error("counter not advanced");
  a_idle: assert property (p_idle) else $error("idle changed state");
  a_neg: assert property (p_neg) else $error("negate wrong");
  a_cmp: assert property (p_cmp) else $error("complement wrong");
  a_orkeep: assert property (p_orkeep) else $error("or disturbed bits");
  a_short: assert property (p_short) else $error("short operand not zero extended");
  a_flg: assert property (p_flg) else $error("logic flags wrong");
  a_mul: assert property (p_mul) else $error("low word not cleared");
  c_fast: cover property (op_valid_i && op_code_i == `AMSL_OP_FAST_NORM);
  c_mul: cover property (op_valid_i && op_code_i == `AMSL_OP_MULRND);
  c_or: cover property (op_valid_i && op_code_i == `AMSL_OP_OR);
endmodule // amsl_dp_props
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the accumulator datapath.
// Assumes amsl_datapath and amsl_dp_props are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "amsl_regs.vh"
module tb;
  logic        clk, rst_n, vld, sel, minus, twos, we, done, minus_n, twos_n;
  logic [2:0]  code, psel;
  logic [1:0]  rsel, osrc, rsel_n, osrc_n;
  logic [23:0] ew, xv, pc, pupd, pval;
  logic [55:0] a, b;
  logic [7:0]  flg;
  int          n_fail, cmp_count, idle_instr, i, u;
  amsl_datapath i_amsl_datapath (
    .ref_clk_i(clk), .rst_n_i(rst_n), .op_valid_i(vld), .op_code_i(code),
    .instr_word_i(24'h000000), .acc_sel_i(sel), .minus_i(minus),
    .input_reg_field_i(rsel), .ext_word_i(ew), .pointer_reg_sel_i(3'h2),
    .or_src_i(osrc), .short_imm_i(ew[5:0]), .shift_src_i(ew), .rounding_op_twos_i(twos),
    .x0_i(xv), .y0_i(xv + 24'h1), .x1_i(xv + 24'h2), .y1_i(xv + 24'h3),
    .acc_a_o(a), .acc_b_o(b), .flag_register_o(flg), .program_counter_o(pc),
    .pointer_upd_o(pupd), .pointer_sel_o(psel), .pointer_we_o(we), .pointer_val_o(pval), .done_o(done));
  // ------------------------------------
  // Tasks
  // ------------------------------------
  task automatic chk(input logic [55:0] g, input logic [55:0] x);
    cmp_count++;
    if (g !== x) begin
      n_fail++;
      $display("Error at %0t: got %h, expected %h", $time, g, x);
    end
  endtask
  task automatic op(input logic [2:0] c, input logic s, input logic [23:0] e, input logic [23:0] x);
    @(posedge clk);
    vld <= 1'b1;
    code <= c;
    sel <= s;
    ew <= e;
    xv <= x;
    osrc <= osrc_n;
    rsel <= rsel_n;
    twos <= twos_n;
    minus <= minus_n;
    @(posedge clk);
    vld <= 1'b0;
    idle_instr++;
    #1;
    chk(done, 56'h1);
  endtask
  task tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #20000;
    n_fail++;
    tally_and_finish;
  end
  initial begin
    {rst_n, vld, sel, minus, twos, code, rsel, osrc, ew, xv} = '0;
    {minus_n, twos_n, rsel_n, osrc_n} = '0;
    n_fail = 0;
    cmp_count = 0;
    idle_instr = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(a | b, 56'h0);
    chk({24'h0, flg, pc}, 56'h0);
    osrc_n = `AMSL_ORSRC_SHORT;
    op(`AMSL_OP_OR, 1'b0, 24'hffff35, 24'h0);
    chk(a, 56'h00000035000000);
    chk(flg, 56'h00);
    osrc_n = `AMSL_ORSRC_LONG;
    op(`AMSL_OP_OR, 1'b0, 24'h800001, 24'h0);
    chk(a, 56'h00800035000000);
    chk(flg, 56'h08);
    osrc_n = `AMSL_ORSRC_REG;
    op(`AMSL_OP_OR, 1'b0, 24'h0, 24'h7fffca);
    chk(a, 56'h00ffffff000000);
    op(`AMSL_OP_COMPL, 1'b0, 24'h0, 24'h0);
    chk({a, flg}, {56'h0, 8'h04});
    osrc_n = `AMSL_ORSRC_LONG;
    op(`AMSL_OP_OR, 1'b0, 24'h000001, 24'h0);
    op(`AMSL_OP_NEGATE, 1'b0, 24'h0, 24'h0);
    chk(a, 56'hffffffff000000);
    op(`AMSL_OP_COMPL, 1'b0, 24'h0, 24'h0);
    chk(a, 56'hff000000000000);
    chk(flg, 56'h04);
    $display("test logic and negate done");
    op(`AMSL_OP_IDLE, 1'b0, 24'h0, 24'h0);
    chk(a, 56'hff000000000000);
    op(`AMSL_OP_NORM_STEP, 1'b0, 24'h0, 24'h0);
    chk({we, a}, {1'b0, 56'hff000000000000});
    chk({pupd, psel, pval}, {24'h0, 3'h2, 24'h0});
    $display("test idle and step done");
    op(`AMSL_OP_OR, 1'b1, 24'h200000, 24'h0);
    op(`AMSL_OP_FAST_NORM, 1'b1, 24'hffffff, 24'h0);
    chk({b, flg[1]}, {56'h00400000000000, 1'b0});
    op(`AMSL_OP_FAST_NORM, 1'b1, 24'h000007, 24'h0);
    chk({b, flg[1]}, {56'h00008000000000, 1'b1});
    op(`AMSL_OP_NEGATE, 1'b1, 24'h0, 24'h0);
    op(`AMSL_OP_FAST_NORM, 1'b1, 24'h000004, 24'h0);
    chk({b, flg[1]}, {56'hfffff800000000, 1'b0});
    $display("test fast align done");
    for (i = 0; i < 8; i++) begin
      rsel_n = i[1:0];
      twos_n = i[2];
      u = (i % 4 + 2) / 2 - (i == 0);
      op(`AMSL_OP_MULRND, 1'b1, 24'h400000, 24'h000001);
      chk(b, {8'h0, u[23:0], 24'h0});
    end
    minus_n = 1'b1;
    rsel_n = 2'h1;
    op(`AMSL_OP_MULRND, 1'b1, 24'h400000, 24'h000001);
    chk(b, 56'hffffffff000000);
    chk(pc, idle_instr);
    $display("test multiply round done");
    tally_and_finish;
  end
endmodule // tb
bind amsl_datapath amsl_dp_props i_amsl_dp_props (.ref_clk_i, .rst_n_i, .op_valid_i, .op_code_i,
  .acc_sel_i, .or_src_i, .acc_a_o, .acc_b_o, .flag_register_o, .program_counter_o, .done_o);
`default_nettype wire
